// File: pkg/vov_pkg.sv
// Package: command codes, field layout, reset values, linear helpers
package vov_pkg;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03; // Send byte
  localparam logic [7:0] CMD_OV_FAULT_LIM = 8'h55; // Fault limit
  localparam logic [7:0] CMD_FAULT_ACTION = 8'h56; // Fault response
  localparam logic [7:0] CMD_WARN_LIMIT   = 8'h57; // Warning limit
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79; // Summary status
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c; // Input status
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  ACTION_RST    = 8'h80;
  localparam logic [15:0] WARN_LIM_RST  = 16'hd3e0;
  localparam logic [15:0] FAULT_LIM_RST = 16'hda00;
  // ----------------------------------------
  // Fault response fields
  // ----------------------------------------
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] RESP_OFF_RETRY = 2'h2; // Only defined code
  localparam logic [2:0] RETRY_NONE     = 3'h0;
  // ----------------------------------------
  // Linear word and status layout
  // ----------------------------------------
  localparam int EXP_MSB  = 15;
  localparam int EXP_LSB  = 11;
  localparam int MANT_MSB = 10;
  localparam int FIX_W    = 48;              // Fixed point width
  localparam logic [5:0] FIX_FRAC = 6'h10;   // Fraction bits
  localparam logic signed [FIX_W-1:0] VIN_MAX_FIX = 48'sh0000_0012_0000;
  localparam int SW_NONE_BIT  = 0;
  localparam int SW_INPUT_BIT = 13;
  localparam int SI_FAULT_BIT = 7;
  localparam int SI_WARN_BIT  = 5;
  // ----------------------------------------
  // Retry timing
  // ----------------------------------------
  localparam int RETRY_UNIT_MS  = 35;
  localparam int CLK_KHZ        = 40000;
  localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_KHZ;
  // ----------------------------------------
  // Types and functions
  // ----------------------------------------
  typedef enum {ST_OFF, ST_RUN, ST_LATCHED, ST_RETRY} vov_state_e;

  // Linear word to signed volts with FIX_FRAC fraction bits
  function automatic logic signed [FIX_W-1:0] vov_lin_fix(
      input logic [15:0] w);
    logic signed [FIX_W-1:0] m;
    logic        [5:0]       sh;
    m  = FIX_W'($signed(w[MANT_MSB:0]));
    sh = 6'({w[EXP_MSB], w[EXP_MSB:EXP_LSB]} + FIX_FRAC);
    return m <<< sh;
  endfunction

  // Accepted span is zero up to the top limit
  function automatic logic vov_in_span(input logic [15:0] w);
    logic signed [FIX_W-1:0] v;
    v = vov_lin_fix(w);
    return (v >= 0) && (v <= VIN_MAX_FIX);
  endfunction
endpackage

// File: pkg/vov_timer_if.sv
// Interface: retry delay timer request and expiry
interface vov_timer_if;
  logic       start;      // One-cycle start pulse
  logic [2:0] delay_code; // Delay field, sampled at start
  logic       expired;    // Level, high once delay has elapsed
  modport ctrl  (output start, delay_code, input expired);
  modport timer (input start, delay_code, output expired);
endinterface

// File: src/vov_retry_timer.sv
// Retry delay timer counting whole retry units
module vov_retry_timer
  import vov_pkg::*;
#(
  parameter int UNIT_CYC = RETRY_UNIT_CYC
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  vov_timer_if.timer tif
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int UW = $clog2(UNIT_CYC + 1);
  localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CYC - 1);

  logic [UW-1:0] unit_cnt_r;  // Cycles in current unit
  logic [2:0]    tick_cnt_r;  // Units still to go after this one
  logic          running_r;   // Delay in progress
  logic          expired_r;   // Delay done, held until next start
  wire           unit_done = running_r && (unit_cnt_r == UNIT_LAST);

  assign tif.expired = expired_r;

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  // Total delay is (code + 1) whole units
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_r <= '0;
      tick_cnt_r <= '0;
      running_r  <= 1'b0;
      expired_r  <= 1'b0;
    end else if (tif.start) begin
      unit_cnt_r <= '0;
      tick_cnt_r <= tif.delay_code;
      running_r  <= 1'b1;
      expired_r  <= 1'b0;
    end else if (unit_done) begin
      unit_cnt_r <= '0;
      // Last unit ends the delay
      if (tick_cnt_r == '0) begin
        running_r <= 1'b0;
        expired_r <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r - 3'h1;
      end
    end else if (running_r) begin
      unit_cnt_r <= unit_cnt_r + UW'(1);
    end
  end
endmodule

// File: src/vov_fault_ctrl.sv
// Input overvoltage supervision: limits, response, status, alert
module vov_fault_ctrl
  import vov_pkg::*;
#(
  parameter int UNIT_CYC = RETRY_UNIT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_ack,
  output logic             cmd_nack,
  input  wire logic        vin_valid,
  input  wire logic [15:0] vin_meas,
  input  wire logic        enable_pin,
  input  wire logic        operation_on,
  input  wire logic        bias_ok,
  input  wire logic        other_fault,
  output logic             output_on,
  output logic             alert_out_n
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;       // Release shift chain
  wire        rst_n = rst_sync_r[1];

  // Assert at once, release two edges later
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // ----------------------------------------
  // Enable pin capture
  // ----------------------------------------
  logic [2:0] en_sync_r;        // Three-stage capture
  logic       en_pin_r;         // Filtered pin level
  wire        en_agree = en_sync_r[1] == en_sync_r[2];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_sync_r <= 3'h0;
    end else begin
      en_sync_r <= {en_sync_r[1:0], enable_pin};
    end
  end

  // Pin only counts once the later stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_pin_r <= 1'b0;
    end else if (en_agree) begin
      en_pin_r <= en_sync_r[2];
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0]  action_r;        // Fault response byte
  logic [15:0] warn_lim_r;      // Warning limit, linear
  logic [15:0] fault_lim_r;     // Fault limit, linear

  // Write and read decode
  wire is_action = cmd_code == CMD_FAULT_ACTION;
  wire is_warn   = cmd_code == CMD_WARN_LIMIT;
  wire is_flim   = cmd_code == CMD_OV_FAULT_LIM;
  wire is_clear  = cmd_code == CMD_CLEAR_FAULTS;
  wire is_sword  = cmd_code == CMD_STATUS_WORD;
  wire is_sinput = cmd_code == CMD_STATUS_INPUT;
  wire span_ok   = vov_in_span(cmd_wdata);
  wire wr_action = cmd_wr && is_action;
  wire wr_warn   = cmd_wr && is_warn && span_ok;
  wire wr_flim   = cmd_wr && is_flim && span_ok;
  wire clr_cmd   = cmd_wr && is_clear;
  wire wr_bad    = cmd_wr && !(wr_action || wr_warn
                               || wr_flim || clr_cmd);
  wire rd_known  = is_action || is_warn || is_flim
                   || is_sword || is_sinput;

  // Stored value kept whole on a rejected write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      action_r    <= ACTION_RST;
      warn_lim_r  <= WARN_LIM_RST;
      fault_lim_r <= FAULT_LIM_RST;
    end else begin
      if (wr_action) action_r <= cmd_wdata[7:0];
      if (wr_warn)   warn_lim_r <= cmd_wdata;
      if (wr_flim)   fault_lim_r <= cmd_wdata;
    end
  end

  // Field views
  wire [1:0] resp_code  = action_r[RESP_MSB:RESP_LSB];
  wire [2:0] retry_code = action_r[RETRY_MSB:RETRY_LSB];
  wire [2:0] delay_code = action_r[DELAY_MSB:DELAY_LSB];

  // ----------------------------------------
  // Input voltage compare
  // ----------------------------------------
  // Linear decode shared by all three words
  wire signed [FIX_W-1:0] vin_fix   = vov_lin_fix(vin_meas);
  wire signed [FIX_W-1:0] warn_fix  = vov_lin_fix(warn_lim_r);
  wire signed [FIX_W-1:0] fault_fix = vov_lin_fix(fault_lim_r);

  logic vin_below_r;            // Last reading under warning limit

  wire ov_fault_ev = vin_valid && (vin_fix > fault_fix);
  wire ov_warn_ev  = vin_valid && (vin_fix > warn_fix);

  // Holds last verdict between readings; starts pessimistic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vin_below_r <= 1'b0;
    end else if (vin_valid) begin
      vin_below_r <= vin_fix < warn_fix;
    end
  end

  // ----------------------------------------
  // Sticky status
  // ----------------------------------------
  logic fault_flag_r;           // Input overvoltage fault
  logic warn_flag_r;            // Input overvoltage warning
  logic alert_r;                // Host notification pending

  // Set beats clear in the same cycle
  wire fault_flag_nxt = ov_fault_ev
                        || (fault_flag_r && !clr_cmd);
  wire warn_flag_nxt  = ov_warn_ev
                        || (warn_flag_r && !clr_cmd);
  wire alert_nxt      = ov_fault_ev || ov_warn_ev
                        || (alert_r && !clr_cmd);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_r <= 1'b0;
      warn_flag_r  <= 1'b0;
      alert_r      <= 1'b0;
    end else begin
      fault_flag_r <= fault_flag_nxt;
      warn_flag_r  <= warn_flag_nxt;
      alert_r      <= alert_nxt;
    end
  end

  assign alert_out_n = !alert_r;

  // Status words built from the flags
  logic [15:0] sword;
  logic [15:0] sinput;
  always_comb begin
    sword  = 16'h0000;
    sinput = 16'h0000;
    sword[SW_NONE_BIT]  = fault_flag_r || warn_flag_r;
    sword[SW_INPUT_BIT] = fault_flag_r || warn_flag_r;
    sinput[SI_FAULT_BIT] = fault_flag_r;
    sinput[SI_WARN_BIT]  = warn_flag_r;
  end

  // ----------------------------------------
  // Command answers
  // ----------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (is_action) begin
      rd_mux = {8'h00, action_r};
    end else if (is_warn) begin
      rd_mux = warn_lim_r;
    end else if (is_flim) begin
      rd_mux = fault_lim_r;
    end else if (is_sword) begin
      rd_mux = sword;
    end else if (is_sinput) begin
      rd_mux = sinput;
    end
  end

  // One-cycle answer after each request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= 16'h0000;
      cmd_ack   <= 1'b0;
      cmd_nack  <= 1'b0;
    end else begin
      cmd_ack  <= (cmd_rd && rd_known) || (cmd_wr && !wr_bad);
      cmd_nack <= (cmd_rd && !rd_known) || wr_bad;
      if (cmd_rd) cmd_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Output response machine
  // ----------------------------------------
  vov_timer_if tif ();          // Retry delay carrier
  vov_state_e  state_r;
  vov_state_e  state_nxt;
  logic        tmr_start;

  // Turned off by pin, command, bias loss or another fault
  wire keep_on  = en_pin_r && operation_on && bias_ok
                  && !other_fault;
  wire may_try  = (resp_code == RESP_OFF_RETRY)
                  && (retry_code != RETRY_NONE);
  wire retry_ok = tif.expired && vin_below_r;

  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    case (state_r)
      ST_OFF: begin
        // Start only when the current reading shows no fault
        if (keep_on && !ov_fault_ev) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!keep_on) begin
          state_nxt = ST_OFF;
        end else if (ov_fault_ev) begin
          // Output drops on every fault
          tmr_start = may_try;
          state_nxt = may_try ? ST_RETRY : ST_LATCHED;
        end
      end
      ST_LATCHED: begin
        if (!keep_on) begin
          state_nxt = ST_OFF;
        end else if (clr_cmd) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RETRY: begin
        if (!keep_on) begin
          state_nxt = ST_OFF;
        end else if (retry_ok) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Output follows the next state so it drops with the fault
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_on <= 1'b0;
    end else begin
      output_on <= state_nxt == ST_RUN;
    end
  end

  // Timer measures from the fault shutdown to the earliest next attempt
  assign tif.start      = tmr_start;
  assign tif.delay_code = delay_code;

  vov_retry_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tif   (tif.timer)
  );
endmodule

// File: verif/vov_fault_ctrl_properties.sv
// Checker: port-level properties of the overvoltage supervisor
module vov_fault_ctrl_properties
  import vov_pkg::*;
#(
  parameter int UNIT_CYC = RETRY_UNIT_CYC
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_ack,
  input wire logic        cmd_nack,
  input wire logic        vin_valid,
  input wire logic [15:0] vin_meas,
  input wire logic        enable_pin,
  input wire logic        operation_on,
  input wire logic        bias_ok,
  input wire logic        other_fault,
  input wire logic        output_on,
  input wire logic        alert_out_n
);
  // ----------------------------------------
  // Command steps
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    cmd_wr || cmd_rd;
  endsequence
  sequence s_answer;
    cmd_ack ^ cmd_nack;
  endsequence
  sequence s_silent;
    !cmd_ack && !cmd_nack;
  endsequence
  // Anything still powered must explain a drop
  sequence s_kept_on;
    operation_on && bias_ok && !other_fault && enable_pin;
  endsequence
  property p_one_answer;
    s_req |=> s_answer;
  endproperty
  property p_quiet;
    !cmd_wr && !cmd_rd |=> s_silent;
  endproperty
  // Negative mantissa means a negative limit
  property p_neg_refused;
    cmd_wr && !cmd_rd && cmd_wdata[10] &&
      (cmd_code == CMD_WARN_LIMIT || cmd_code == CMD_OV_FAULT_LIM)
      |=> cmd_nack;
  endproperty
  property p_read_byte;
    cmd_rd && !cmd_wr && cmd_code == CMD_FAULT_ACTION
      |=> cmd_ack && cmd_rdata[15:8] == 8'h00;
  endproperty
  property p_rdata_hold;
    !cmd_rd |=> $stable(cmd_rdata);
  endproperty
  property p_alert_set;
    $fell(alert_out_n) |-> $past(vin_valid);
  endproperty
  property p_alert_hold;
    !alert_out_n && !(cmd_wr && cmd_code == CMD_CLEAR_FAULTS)
      |=> !alert_out_n;
  endproperty
  property p_rise_needs_on;
    $rose(output_on) |-> $past(operation_on) && $past(bias_ok) &&
      !$past(other_fault);
  endproperty
  property p_other_off;
    other_fault |-> ##[1:2] !output_on;
  endproperty
  property p_fall_alert;
    $fell(output_on) ##0 s_kept_on ##0 $past(enable_pin, 6) &&
      $past(operation_on) && $past(bias_ok) && !$past(other_fault, 2)
      |-> !alert_out_n;
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("request without single answer");
  a_quiet: assert property (p_quiet)
    else $error("answer without request");
  a_neg_refused: assert property (p_neg_refused)
    else $error("negative limit accepted");
  a_read_byte: assert property (p_read_byte)
    else $error("response byte read wrong");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  a_alert_set: assert property (p_alert_set)
    else $error("alert without reading");
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert released without clear");
  a_rise_needs_on: assert property (p_rise_needs_on)
    else $error("output rose while off");
  a_other_off: assert property (p_other_off)
    else $error("output kept on in other fault");
  a_fall_alert: assert property (p_fall_alert)
    else $error("output dropped with no fault");
endmodule

bind vov_fault_ctrl vov_fault_ctrl_properties #(.UNIT_CYC(UNIT_CYC)) u_props (
  .mclk(mclk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
  .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .vin_valid(vin_valid),
  .vin_meas(vin_meas), .enable_pin(enable_pin),
  .operation_on(operation_on), .bias_ok(bias_ok),
  .other_fault(other_fault), .output_on(output_on),
  .alert_out_n(alert_out_n));

// File: verif/vov_host_model.sv
// Host model: issues one register command at a time
module vov_host_model (
  input  wire logic  mclk,
  output logic       cmd_wr,
  output logic       cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One-cycle request; released fields show inverse, not stale data
  task automatic xfer(input logic wr, input logic [7:0] c,
                      input logic [15:0] d);
    @(negedge mclk);
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule

// File: verif/vov_fault_ctrl_tb.sv
// Testbench: register commands, warnings, faults and restarts
module vov_fault_ctrl_tb
  import vov_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UNIT = 20; // Short retry unit
  typedef struct packed {
    logic        nk;
    logic        chk;
    logic [15:0] rd;
  } vov_exp_s;
  logic mclk = 1'b0, rstn = 1'b0, vin_valid = 1'b0;
  logic enable_pin = 1'b1, operation_on = 1'b1;
  logic bias_ok = 1'b1, other_fault = 1'b0;
  logic [15:0] vin_meas = 16'h0000, cmd_wdata, cmd_rdata;
  logic [7:0] cmd_code, b;
  logic cmd_wr, cmd_rd, cmd_ack, cmd_nack, output_on, alert_out_n;
  vov_exp_s q[$];
  vov_exp_s e;
  int n_fail = 0, total_checks = 0, n;
  logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  always #12.5 mclk = ~mclk;
  vov_host_model u_host (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  vov_fault_ctrl #(.UNIT_CYC(UNIT)) u_dut (.mclk(mclk), .rstn(rstn),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .cmd_nack(cmd_nack), .vin_valid(vin_valid), .vin_meas(vin_meas),
    .enable_pin(enable_pin), .operation_on(operation_on),
    .bias_ok(bias_ok), .other_fault(other_fault),
    .output_on(output_on), .alert_out_n(alert_out_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] ex);
    total_checks++;
    if (seen !== ex) begin
      n_fail++;
      $display("ERROR %0t saw %h expected %h", $time, seen, ex);
    end
  endtask
  task automatic chk1(input logic s, input logic ex);
    check({15'h0000, s}, {15'h0000, ex});
  endtask
  // Note the answer first, then issue the command
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input logic nk);
    q.push_back('{nk, 1'b0, 16'h0000});
    u_host.xfer(1'b1, c, d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] d,
                    input logic nk);
    q.push_back('{nk, 1'b1, d});
    u_host.xfer(1'b0, c, 16'h0000);
  endtask
  task automatic vin(input logic [15:0] v);
    @(negedge mclk);
    vin_valid = 1'b1;
    vin_meas = v;
    @(negedge mclk);
    vin_valid = 1'b0;
    vin_meas = ~v;
  endtask
  // Bounded wait for the power stage to come up
  task automatic wait_on(input int lim);
    n = 0;
    while (output_on !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Monitor: every answer takes the oldest note
  always @(negedge mclk) begin
    if ((cmd_ack | cmd_nack) === 1'b1) begin
      if (q.size() == 0) begin
        check(16'hffff, 16'h0000);
      end else begin
        e = q.pop_front();
        chk1(cmd_nack, e.nk);
        if (e.chk) check(cmd_rdata, e.rd);
      end
    end
  end
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(negedge mclk);
    n_fail++;
    complete_run();
  end
  initial begin
    void'($urandom(77));
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (12) @(negedge mclk);
    chk1(output_on, 1'b1);
    rd(CMD_FAULT_ACTION, 16'h0080, 1'b0);
    rd(CMD_WARN_LIMIT, 16'hd3e0, 1'b0);
    rd(CMD_OV_FAULT_LIM, 16'hda00, 1'b0);
    rd(8'h20, 16'h0000, 1'b1);
    wr(CMD_STATUS_WORD, 16'h0000, 1'b1);
    wr(CMD_WARN_LIMIT, 16'h07ff, 1'b1);
    wr(CMD_WARN_LIMIT, 16'h0813, 1'b1);
    wr(CMD_OV_FAULT_LIM, 16'h0012, 1'b0);
    wr(CMD_OV_FAULT_LIM, 16'h0010, 1'b0);
    wr(CMD_WARN_LIMIT, 16'hf81c, 1'b0);
    rd(CMD_WARN_LIMIT, 16'hf81c, 1'b0);
    repeat (4) begin
      b = 8'($urandom);
      wr(CMD_FAULT_ACTION, {8'hff, b}, 1'b0);
      rd(CMD_FAULT_ACTION, {8'h00, b}, 1'b0);
    end
    // Warning only: 15 V between the two limits
    vin(16'h000f);
    chk1(alert_out_n, 1'b0);
    chk1(output_on, 1'b1);
    rd(CMD_STATUS_WORD, 16'h2001, 1'b0);
    rd(CMD_STATUS_INPUT, 16'h0020, 1'b0);
    vin(16'h0005);
    chk1(alert_out_n, 1'b0);
    wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
    chk1(alert_out_n, 1'b1);
    // Only code 10 restarts by itself
    foreach (codes[i]) begin
      wr(CMD_FAULT_ACTION, {8'h00, codes[i], 6'h08}, 1'b0);
      vin(16'h0011);
      chk1(output_on, 1'b0);
      chk1(alert_out_n, 1'b0);
      rd(CMD_STATUS_INPUT, 16'h00a0, 1'b0);
      vin(16'h0005);
      wait_on(3 * UNIT);
      chk1(output_on, codes[i] == 2'h2);
      wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
      wait_on(10);
    end
    // No retries: stays off until cleared
    wr(CMD_FAULT_ACTION, 16'h0080, 1'b0);
    vin(16'h0011);
    vin(16'h0005);
    repeat (5 * UNIT) @(negedge mclk);
    chk1(output_on, 1'b0);
    wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
    wait_on(10);
    chk1(output_on, 1'b1);
    // Restart held while input stays above warning
    wr(CMD_FAULT_ACTION, 16'h008a, 1'b0);
    vin(16'h0011);
    vin(16'h000f);
    wait_on(5 * UNIT);
    chk1(output_on, 1'b0);
    vin(16'h0005);
    wait_on(10);
    chk1(output_on, 1'b1);
    // Spacing of (2+1) units, measured from the fault
    vin(16'h0011);
    vin(16'h0005);
    wait_on(10 * UNIT);
    chk1(n >= 3 * UNIT - 4 && n <= 3 * UNIT + 2, 1'b1);
    // Each off condition stops the running, then the retrying output
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      {enable_pin, operation_on, bias_ok, other_fault} =
        4'he ^ (4'h8 >> i);
      repeat (8) @(negedge mclk);
      chk1(output_on, 1'b0);
      {enable_pin, operation_on, bias_ok, other_fault} = 4'he;
      wait_on(20);
      chk1(output_on, 1'b1);
      // Retry pending: off must win over the expiring delay
      vin(16'h0011);
      @(negedge mclk);
      {enable_pin, operation_on, bias_ok, other_fault} =
        4'he ^ (4'h8 >> i);
      vin(16'h0005);
      repeat (4 * UNIT) @(negedge mclk);
      chk1(output_on, 1'b0);
      {enable_pin, operation_on, bias_ok, other_fault} = 4'he;
      wait_on(20);
      chk1(output_on, 1'b1);
    end
    // Turning off and on again leaves the flags standing
    rd(CMD_STATUS_INPUT, 16'h00a0, 1'b0);
    repeat (4) @(negedge mclk);
    check(16'(q.size()), 16'h0000);
    complete_run();
  end
endmodule
